/* in_sync.v */
// Three-stage pin synchroniser with agreement filter
module in_sync (
  input  wire aclk,
  input  wire aresetn,
  input  wire din,
  output reg  dout
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  // Line idles high, so all stages reset high
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      dout <= 1'b1;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Change counts only once stages two and three agree
      if (s2_r == s3_r) begin
        dout <= s2_r;
      end
    end
  end

endmodule

/* serial_peer.sv */
module serial_peer (
  input  wire logic aclk,
  input  wire logic txd,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned bit_cyc = 64; // Set by the bench from the baud code
  initial rxd = 1'b1; // Idle high
  // Start low, data LSB first, stop high
  task automatic send(input logic [7:0] d, input int nb);
    rxd <= 1'b0;
    repeat (bit_cyc) @(posedge aclk);
    for (int i = 0; i < nb; i++) begin
      rxd <= d[i];
      repeat (bit_cyc) @(posedge aclk);
    end
    rxd <= 1'b1;
    repeat (bit_cyc) @(posedge aclk);
  endtask
  // Mid-bit sampling; a start bit gone by the half-bit point clears ok
  task automatic recv(input int nb, output logic [7:0] d, output logic ok);
    d = 8'h00;
    for (int i = 0; i < 90000 && txd !== 1'b0; i++) @(posedge aclk);
    repeat (bit_cyc / 2) @(posedge aclk);
    ok = !txd;
    for (int i = 0; i < nb; i++) begin
      repeat (bit_cyc) @(posedge aclk);
      d[i] = txd;
    end
    repeat (bit_cyc) @(posedge aclk);
    ok = ok & txd;
  endtask
endmodule

/* sync_fifo.v */
// Small flop-based FIFO with valid/ready on both sides
module sync_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  // Honest full and empty from the occupancy count
  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data  = mem_r[rd_ptr_r];

  // Storage write, no reset needed for data
  always @(posedge aclk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap naturally since depth is a power of two
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* test_uart_baud.sv */
`include "uart_consts.vh"

module test_uart_baud;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, ok;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, rdv;
  logic [1:0]  rr;
  logic [7:0]  got, q [6];
  logic [7:0]  codes [3] = '{8'h10, 8'h12, 8'h4A};
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, rxd, txd;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  int          n_mismatch, tests_run;
  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  uart_baud dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rxd(rxd), .txd(txd)
  );
  serial_peer peer_u (.aclk(aclk), .txd(txd), .rxd(rxd));
  ////////////////////////////////////////////////////////////////////////////
  // Bit time 2^(n+1) * (k + 16) clocks
  function automatic int bit_cycles(input logic [7:0] c);
    return (2 << c[6:4]) * (c[3:0] + 16);
  endfunction
  // Seven-bit mode drops the top bit
  function automatic logic [7:0] exp_byte(input logic [7:0] d, input logic l7);
    return l7 ? {1'b0, d[6:0]} : d;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Write: address and data together, each released once taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    int n, dly;
    logic done;
    dly = $urandom_range(2);
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (dly == 0);
    // No cycle limit here; only the watchdog ends a hang
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      done = (s_axi_bvalid === 1'b1) && s_axi_bready;
      n++;
      // Late ready rises no later than the response, which appears on the third cycle at the earliest
      if (!done && n == dly) s_axi_bready <= 1'b1;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n, dly;
    logic done;
    dly = $urandom_range(2);
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (dly == 0);
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      done = (s_axi_rvalid === 1'b1) && s_axi_rready;
      n++;
      if (!done && n == dly) s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Frames both ways at once, then status and buffer
  task automatic swap(input logic l7);
    logic [7:0] t, v;
    t = 8'($urandom) | 8'h80;
    v = 8'($urandom) | 8'h80;
    fork
      peer_u.send(v, l7 ? 7 : 8);
      peer_u.recv(l7 ? 7 : 8, got, ok);
      wr(`OFS_DATA, t, rr);
    join
    chk(got, exp_byte(t, l7));
    chk(ok, 1'b1);
    rd(`OFS_MODE, rdv, rr);
    chk(rdv[2:0], 3'h1);
    rd(`OFS_DATA, rdv, rr);
    chk(rdv, exp_byte(v, l7));
    rd(`OFS_MODE, rdv, rr);
    chk(rdv[0], 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(18));
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} <= 10'h0;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(`OFS_MODE, rdv, rr);
    chk(rdv, 32'h0);
    rd(`OFS_BAUD, rdv, rr);
    chk(rdv, 32'h0);
    rd(4'h2, rdv, rr);
    chk(rr, `RESP_SLVERR);
    wr(4'h2, 8'h55, rr);
    chk(rr, `RESP_SLVERR);
    // Status bits ignore writes; bit op clears length select
    wr(`OFS_MODE, 8'hFF, rr);
    chk(rr, `RESP_OKAY);
    rd(`OFS_MODE, rdv, rr);
    chk(rdv, 32'hE0);
    wr(`OFS_MODE_BIT, 8'h05, rr);
    rd(`OFS_MODE, rdv, rr);
    chk(rdv, 32'hC0);
    $display("test registers done");
    foreach (codes[i]) begin
      wr(`OFS_BAUD, codes[i], rr);
      rd(`OFS_BAUD, rdv, rr);
      chk(rdv, {24'h0, codes[i]});
      peer_u.bit_cyc = bit_cycles(codes[i]);
      for (int l = 0; l < 2; l++) begin
        wr(`OFS_MODE_BIT, 8'h05 | 8'(l << 3), rr);
        swap(l[0]);
      end
    end
    $display("test baud codes done");
    // Six writes overrun the queue; the last waits for a slot
    wr(`OFS_BAUD, 8'h10, rr);
    peer_u.bit_cyc = bit_cycles(8'h10);
    wr(`OFS_MODE_BIT, 8'h05, rr);
    foreach (q[i]) q[i] = 8'($urandom);
    fork
      begin
        foreach (q[i]) wr(`OFS_DATA, q[i], rr);
        rd(`OFS_MODE, rdv, rr);
        chk(rdv[3], 1'b1);
      end
      foreach (q[i]) begin
        peer_u.recv(8, got, ok);
        chk(got, q[i]);
      end
    join
    $display("test queue done");
    results();
  end
  // Watchdog: runs need about 22500 cycles, over 2.5 times that is a hang
  initial begin
    repeat (60000) @(posedge aclk);
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end
endmodule

/* uart_baud.v */
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`include "uart_consts.vh"

module uart_baud (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        rxd,
  output reg         txd
);

  localparam RX_IDLE  = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA  = 2'h2;
  localparam RX_STOP  = 2'h3;

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  reg        aw_held_r;
  reg        w_held_r;
  reg  [3:0] waddr_r;
  reg  [7:0] wbyte_r;
  reg        wlane_r;

  reg  [2:0] mode_ctl_r;
  reg  [7:0] baud_ctl_r;
  reg        rx_full_r;
  reg        overrun_r;
  reg        framing_r;
  reg  [7:0] rx_buf_r;

  reg  [7:0] pre_cnt_r;
  reg        fine_tick_r;

  reg        tx_busy_r;
  reg  [8:0] tx_sh_r;
  reg  [3:0] tx_left_r;
  reg  [4:0] tx_tmr_r;

  reg  [1:0] rx_state_r;
  reg  [4:0] rx_tmr_r;
  reg  [3:0] rx_cnt_r;
  reg  [7:0] rx_sh_r;

  reg  [7:0] rd_byte;

  wire       rx_line;
  wire       q_in_ready;
  wire       q_out_valid;
  wire       q_out_ready;
  wire [7:0] q_out_data;

  wire tx_en = mode_ctl_r[2];
  wire rx_en = mode_ctl_r[1];
  wire len7  = mode_ctl_r[0];

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshakes and write channel

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire b_take  = s_axi_bvalid & s_axi_bready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire r_take  = s_axi_rvalid & s_axi_rready;

  wire wr_data  = (waddr_r == `OFS_DATA);
  wire wr_mode  = (waddr_r == `OFS_MODE);
  wire wr_baud  = (waddr_r == `OFS_BAUD);
  wire wr_bitop = (waddr_r == `OFS_MODE_BIT);
  wire wr_known = wr_data | wr_mode | wr_baud | wr_bitop;

  // A full transmit queue stalls the response, so writes never drop
  wire wr_go = aw_held_r & w_held_r & ~s_axi_bvalid &
               (~wr_data | ~wlane_r | q_in_ready);
  wire do_wr = wr_go & wlane_r;

  wire aw_held_nxt = wr_go ? 1'b0 : (aw_held_r | aw_take);
  wire w_held_nxt  = wr_go ? 1'b0 : (w_held_r | w_take);
  wire bvalid_nxt  = wr_go ? 1'b1 : (b_take ? 1'b0 : s_axi_bvalid);
  wire rvalid_nxt  = ar_take ? 1'b1 : (r_take ? 1'b0 : s_axi_rvalid);

  // Address and data are caught independently, either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      waddr_r       <= 4'h0;
      wbyte_r       <= 8'h00;
      wlane_r       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      if (aw_take) begin
        waddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wbyte_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end
      aw_held_r     <= aw_held_nxt;
      w_held_r      <= w_held_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      // One write in flight: ready reopens after the response
      s_axi_awready <= ~aw_held_nxt & ~bvalid_nxt;
      s_axi_wready  <= ~w_held_nxt & ~bvalid_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  wire rd_data = (s_axi_araddr == `OFS_DATA);
  wire rd_clr  = ar_take & rd_data;

  // Read mux; data offset returns the receive side only
  always @* begin
    rd_byte = 8'h00;
    case (s_axi_araddr)
      `OFS_DATA: rd_byte = rx_buf_r;
      `OFS_MODE: begin
        rd_byte[`MODE_TX_EN]   = tx_en;
        rd_byte[`MODE_RX_EN]   = rx_en;
        rd_byte[`MODE_LEN7]    = len7;
        rd_byte[`STAT_TX_BUSY] = tx_busy_r | q_out_valid;
        rd_byte[`STAT_OVERRUN] = overrun_r;
        rd_byte[`STAT_FRAMING] = framing_r;
        rd_byte[`STAT_RX_FULL] = rx_full_r;
      end
      `OFS_BAUD: rd_byte = baud_ctl_r;
      default:   rd_byte = 8'h00;
    endcase
  end

  // Read answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_rdata <= {24'h000000, rd_byte};
        if (s_axi_araddr == `OFS_DATA || s_axi_araddr == `OFS_MODE ||
            s_axi_araddr == `OFS_BAUD) begin
          s_axi_rresp <= `RESP_OKAY;
        end else begin
          s_axi_rresp <= `RESP_SLVERR;
        end
      end
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_arready <= ~rvalid_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control registers

  wire [2:0] bit_idx = wbyte_r[`BITOP_IDX_HI:0];
  wire [2:0] bit_ofs = bit_idx - `BITOP_IDX_MIN;

  // Mode takes a whole byte or one bit; baud only a whole byte
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_ctl_r <= `MODE_CTL_RST;
      baud_ctl_r <= `BAUD_RST;
    end else if (do_wr) begin
      if (wr_mode) begin
        mode_ctl_r <= wbyte_r[`MODE_TX_EN:`MODE_LEN7];
      end
      if (wr_bitop && bit_idx >= `BITOP_IDX_MIN) begin
        mode_ctl_r[bit_ofs[1:0]] <= wbyte_r[`BITOP_VAL];
      end
      if (wr_baud) begin
        baud_ctl_r <= wbyte_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Baud generator

  // Invalid codes are not trapped; the divider just follows the fields
  wire [2:0] pre_n = baud_ctl_r[`BAUD_N_HI:`BAUD_N_LO];
  wire [3:0] mod_k = baud_ctl_r[`BAUD_K_HI:`BAUD_K_LO];
  wire [8:0] pre_pow = 9'h002 << pre_n;
  wire [8:0] pre_m1  = pre_pow - 9'h001;
  wire [4:0] mod_lim = {1'b0, mod_k} + `MOD_BASE_M1;
  wire [4:0] mod_half = {1'b0, mod_lim[4:1]};

  // Fine tick at fx / 2^(n+1); bit time is k+16 ticks
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_r   <= 8'h00;
      fine_tick_r <= 1'b0;
    end else if (pre_cnt_r >= pre_m1[7:0]) begin
      pre_cnt_r   <= 8'h00;
      fine_tick_r <= 1'b1;
    end else begin
      pre_cnt_r   <= pre_cnt_r + 8'h01;
      fine_tick_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit queue and transmitter

  sync_fifo #(
    .WIDTH (8),
    .DEPTH (`TXQ_DEPTH),
    .AW    (`TXQ_AW)
  ) u_txq (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (do_wr & wr_data),
    .in_ready  (q_in_ready),
    .in_data   (wbyte_r),
    .out_valid (q_out_valid),
    .out_ready (q_out_ready),
    .out_data  (q_out_data)
  );

  // Queue drains only while idle and enabled; this is what fills it
  assign q_out_ready = ~tx_busy_r & tx_en;

  // Start bit goes out on load; shifter holds data then stop
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_busy_r <= 1'b0;
      tx_sh_r   <= 9'h1FF;
      tx_left_r <= 4'h0;
      tx_tmr_r  <= 5'h00;
      txd       <= 1'b1;
    end else if (!tx_busy_r) begin
      if (q_out_valid && tx_en) begin
        tx_busy_r <= 1'b1;
        txd       <= 1'b0;
        tx_tmr_r  <= 5'h00;
        if (len7) begin
          tx_sh_r   <= {2'b11, q_out_data[6:0]};
          tx_left_r <= `TX_LEFT_7;
        end else begin
          tx_sh_r   <= {1'b1, q_out_data};
          tx_left_r <= `TX_LEFT_8;
        end
      end
    end else if (fine_tick_r) begin
      if (tx_tmr_r >= mod_lim) begin
        tx_tmr_r <= 5'h00;
        if (tx_left_r == 4'h0) begin
          tx_busy_r <= 1'b0;
        end else begin
          txd       <= tx_sh_r[0];
          tx_sh_r   <= {1'b1, tx_sh_r[8:1]};
          tx_left_r <= tx_left_r - 4'h1;
        end
      end else begin
        tx_tmr_r <= tx_tmr_r + 5'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receiver, independent of the transmitter

  in_sync u_rx_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (rxd),
    .dout    (rx_line)
  );

  wire rx_bit_end = fine_tick_r & (rx_tmr_r >= mod_lim);
  wire rx_load    = (rx_state_r == RX_STOP) & rx_bit_end;
  wire [3:0] rx_bits = len7 ? `RX_BITS_7 : `RX_BITS_8;

  // Start is checked at mid-bit, then samples fall one bit apart
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_r <= RX_IDLE;
      rx_tmr_r   <= 5'h00;
      rx_cnt_r   <= 4'h0;
      rx_sh_r    <= 8'h00;
    end else begin
      case (rx_state_r)
        RX_IDLE: begin
          rx_tmr_r <= 5'h00;
          rx_cnt_r <= 4'h0;
          if (rx_en && !rx_line) begin
            rx_state_r <= RX_START;
          end
        end
        RX_START: begin
          if (fine_tick_r) begin
            if (rx_tmr_r >= mod_half) begin
              rx_tmr_r   <= 5'h00;
              // Glitch shorter than half a bit is dropped
              rx_state_r <= rx_line ? RX_IDLE : RX_DATA;
            end else begin
              rx_tmr_r <= rx_tmr_r + 5'h01;
            end
          end
        end
        RX_DATA: begin
          if (rx_bit_end) begin
            rx_tmr_r <= 5'h00;
            rx_sh_r  <= {rx_line, rx_sh_r[7:1]};
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r + 4'h1 == rx_bits) begin
              rx_state_r <= RX_STOP;
            end
          end else if (fine_tick_r) begin
            rx_tmr_r <= rx_tmr_r + 5'h01;
          end
        end
        RX_STOP: begin
          if (rx_bit_end) begin
            rx_state_r <= RX_IDLE;
          end else if (fine_tick_r) begin
            rx_tmr_r <= rx_tmr_r + 5'h01;
          end
        end
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive buffer and status flags

  // New byte always replaces the buffer; full and framing sets beat a same-cycle read
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf_r  <= 8'h00;
      rx_full_r <= 1'b0;
      overrun_r <= 1'b0;
      framing_r <= 1'b0;
    end else begin
      if (rx_load) begin
        if (len7) begin
          rx_buf_r <= {1'b0, rx_sh_r[7:1]};
        end else begin
          rx_buf_r <= rx_sh_r;
        end
      end
      if (rx_load) begin
        rx_full_r <= 1'b1;
      end else if (rd_clr) begin
        rx_full_r <= 1'b0;
      end
      if (rx_load && rx_full_r && !rd_clr) begin
        overrun_r <= 1'b1;
      end else if (rd_clr) begin
        overrun_r <= 1'b0;
      end
      if (rx_load && !rx_line) begin
        framing_r <= 1'b1;
      end else if (rd_clr) begin
        framing_r <= 1'b0;
      end
    end
  end

endmodule

/* uart_baud_monitor.sv */
`include "uart_consts.vh"

module uart_baud_monitor (
  input wire        aclk,
  input wire        aresetn,
  input wire [3:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [3:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        txd
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Answers stand until taken
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  // Read answer one cycle after the take, one byte wide
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read late");
  property p_byte_wide;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_byte_wide: assert property (p_byte_wide) else $error("rdata wide");
  // Holes in the map answer with an error
  property p_rd_hole;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h2
      |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_rd_hole: assert property (p_rd_hole) else $error("hole read");
  property p_wr_hole;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == 4'h2
      |-> ##[1:3] s_axi_bvalid && s_axi_bresp == `RESP_SLVERR;
  endproperty
  a_wr_hole: assert property (p_wr_hole) else $error("hole write");
  property p_ready_back;
    s_axi_bvalid && s_axi_bready |-> !s_axi_awready ##1 s_axi_awready;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("awready");
  // A start bit is never a glitch
  property p_start_bit;
    $fell(txd) |-> !txd [*8];
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("short start");
  c_hole: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
  c_frame: cover property ($fell(txd));
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind uart_baud uart_baud_monitor mon_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .txd(txd)
);

/* uart_consts.vh */
`ifndef UART_CONSTS_VH
`define UART_CONSTS_VH

// Register byte offsets on the AXI4-Lite port
`define OFS_DATA      4'h0
`define OFS_MODE      4'h4
`define OFS_BAUD      4'h8
`define OFS_MODE_BIT  4'hC

// Mode register fields
`define MODE_TX_EN    7
`define MODE_RX_EN    6
`define MODE_LEN7     5
`define STAT_TX_BUSY  3
`define STAT_OVERRUN  2
`define STAT_FRAMING  1
`define STAT_RX_FULL  0

// Single-bit write op: index field and value bit
`define BITOP_IDX_HI  2
`define BITOP_VAL     3
`define BITOP_IDX_MIN 3'h5

// Baud register fields
`define BAUD_N_HI     6
`define BAUD_N_LO     4
`define BAUD_K_HI     3
`define BAUD_K_LO     0

// Reset values
`define MODE_CTL_RST  3'h0
`define BAUD_RST      8'h00

// Modulo base of the divider, minus one (k + 16 ticks per bit)
`define MOD_BASE_M1   5'h0F

// Frame lengths after the start bit (data plus stop for TX, data only for RX)
`define TX_LEFT_8     4'h9
`define TX_LEFT_7     4'h8
`define RX_BITS_8     4'h8
`define RX_BITS_7     4'h7

// Transmit buffer depth
`define TXQ_DEPTH     4
`define TXQ_AW        2

// AXI responses
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif
